//--- rtl/wdrs_regs.vh
`ifndef WDRS_REGS_VH
`define WDRS_REGS_VH
// Register offsets
`define WDRS_ADDR_CTRL      16'hffae
`define WDRS_ADDR_IRQ_STAT  16'hffb0
`define WDRS_ADDR_IRQ_MASK  16'hffb2
`define WDRS_ADDR_CFG       16'hffb4
// Control register fields
`define WDRS_BIT_PRESCALE   0
`define WDRS_BIT_WDT_FLAG   1
`define WDRS_BIT_SW_FLAG    2
`define WDRS_BIT_SHORT_FLAG 3
`define WDRS_BIT_LONG_FLAG  4
`define WDRS_BIT_PON_FLAG   5
`define WDRS_RELOAD_HI      15
`define WDRS_RELOAD_LO      8
// Config register fields
`define WDRS_BIT_DISABLE    0
`define WDRS_BIT_BIDIR      1
// Interrupt status fields
`define WDRS_IRQ_OVF        0
`define WDRS_IRQ_SHORT      1
`define WDRS_IRQ_LONG       2
`define WDRS_IRQ_W          3
// Prescale divide limits, minus one
`define WDRS_DIV2_LAST      7'h01
`define WDRS_DIV128_LAST    7'h7f
// Timing: half clock period in ps, filter accept time in ps
`define WDRS_TCL_PS         12500
`define WDRS_FILT_ACCEPT_PS 500000
`define WDRS_LONG_TCL       1044
`define WDRS_MIN_TCL        4
`define WDRS_CNT_W          11
// Internal reset length and the cycle at which the device lets go of the pin
`define WDRS_IRST_LAST      11'h00f
`define WDRS_IRST_REL       11'h007
`endif

//--- rtl/wdrs_sync.v
`timescale 1ns/100ps
// Three-stage input synchroniser; a change counts once stages two and three agree
module wdrs_sync (
  input  wire core_clk,
  input  wire rst_b,
  input  wire clk_en,
  input  wire pin_in,
  output reg  level_r
);
  reg s1_r;
  reg s2_r;
  reg s3_r;

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_r    <= 1'b1;
      s2_r    <= 1'b1;
      s3_r    <= 1'b1;
      level_r <= 1'b1;
    end else if (clk_en) begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level_r <= s3_r;
      end
    end
  end
endmodule // wdrs_sync

//--- rtl/wdrs_watchdog.v
// The plain strobed port was decided locally.
`timescale 1ns/100ps
`include "wdrs_regs.vh"
module wdrs_watchdog (
  input  wire        core_clk,
  input  wire        rst_b,
  input  wire        clk_en,
  input  wire [15:0] addr,
  input  wire [15:0] wr_data,
  input  wire        wr_stb,
  input  wire        rd_stb,
  output reg  [15:0] rd_data_r,
  input  wire        end_of_init_instruction,
  input  wire        service_instruction,
  input  wire        software_reset_instruction,
  input  wire        power_on_detect,
  input  wire        supply_fail_detect,
  input  wire        reset_input_pin,
  input  wire        power_down_pin,
  output reg         reset_output_pin_b_r,
  output reg         reset_input_pin_out_r,
  output reg         reset_input_pin_oe_r,
  output reg         internal_reset_r,
  output reg         irq_r
);
  // Filter accept time in cycles, rounded up; HALF_CPU_CLOCK_PERIOD is half a cycle
  localparam integer CYC_PS     = 2 * `WDRS_TCL_PS;
  localparam integer FILT_CYC   = (`WDRS_FILT_ACCEPT_PS + CYC_PS - 1) / CYC_PS;
  localparam integer MINP_CYC   = (`WDRS_MIN_TCL + 1) / 2;
  localparam integer ACC_CYC    = (FILT_CYC > MINP_CYC) ? FILT_CYC : MINP_CYC;
  localparam integer LONG_CYC   = ACC_CYC + (`WDRS_LONG_TCL + 1) / 2;
  localparam [`WDRS_CNT_W-1:0] ACC_LAST  = ACC_CYC[`WDRS_CNT_W-1:0] - 1'b1;
  localparam [`WDRS_CNT_W-1:0] LONG_LAST = LONG_CYC[`WDRS_CNT_W-1:0];
  localparam [`WDRS_CNT_W-1:0] LONG_SAT  = LONG_LAST + 1'b1;
  // Length of the internal reset pulse after overflow or software reset
  localparam [`WDRS_CNT_W-1:0] IRST_LAST = `WDRS_IRST_LAST;
  // Own drive ends early so the filtered pin shows only the far side at the end
  localparam [`WDRS_CNT_W-1:0] IRST_REL  = `WDRS_IRST_REL;

  localparam [1:0] ST_IDLE  = 2'b00;
  localparam [1:0] ST_PULSE = 2'b01;
  localparam [1:0] ST_WAIT  = 2'b10;

  // Both pins cross into the clock domain the same way
  wire [1:0] pin_raw = {power_down_pin, reset_input_pin};
  wire [1:0] pin_sync;
  genvar     gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
      wdrs_sync u_sync (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .clk_en   (clk_en),
        .pin_in   (pin_raw[gi]),
        .level_r  (pin_sync[gi])
      );
    end
  endgenerate
  wire       pin_lvl = pin_sync[0];
  wire       rpd_lvl = pin_sync[1];

  reg                  prescale_select_r;
  reg  [7:0]           reload_high_byte_r;
  reg  [4:0]           flags_r;
  reg  [15:0]          count_r;
  reg  [6:0]           div_r;
  reg                  init_done_r;
  reg                  disable_r;
  reg                  bidir_r;
  reg  [`WDRS_IRQ_W-1:0] irq_stat_r;
  reg  [`WDRS_IRQ_W-1:0] irq_mask_r;
  reg  [1:0]           state_r;
  reg  [`WDRS_CNT_W-1:0] pulse_cnt_r;
  reg  [`WDRS_CNT_W-1:0] irst_cnt_r;

  function [1:0] ctrl_hit;
    input [15:0] a;
    begin
      if (a == `WDRS_ADDR_CTRL) begin
        ctrl_hit = 2'h1;
      end else if (a == `WDRS_ADDR_IRQ_STAT) begin
        ctrl_hit = 2'h2;
      end else if (a == `WDRS_ADDR_IRQ_MASK) begin
        ctrl_hit = 2'h3;
      end else begin
        ctrl_hit = 2'h0;
      end
    end
  endfunction

  wire       wr_ctrl = wr_stb && (ctrl_hit(addr) == 2'h1);
  wire       wr_mask = wr_stb && (ctrl_hit(addr) == 2'h3);
  wire       wr_cfg  = wr_stb && (addr == `WDRS_ADDR_CFG);
  wire       rd_stat = rd_stb && (ctrl_hit(addr) == 2'h2);

  wire [6:0] div_last = prescale_select_r ? `WDRS_DIV128_LAST : `WDRS_DIV2_LAST;
  wire       wd_tick  = (div_r == div_last);
  wire       wd_run   = !disable_r && !internal_reset_r;
  wire       overflow = wd_run && wd_tick && (count_r == 16'hffff);
  wire       pin_low  = !pin_lvl;
  // Device may drive the reset pin only in bidirectional mode with power-down high
  wire       may_drive = bidir_r && rpd_lvl;

  // Pulse length bounds, counted from the first filtered low sample
  wire       in_pulse   = (state_r == ST_PULSE);
  wire       short_evt  = in_pulse && !pin_low && (pulse_cnt_r > ACC_LAST)
                          && (pulse_cnt_r <= LONG_LAST);
  // Counter parks one past the long bound, so a long pulse reports once
  wire       long_evt   = in_pulse && pin_low && (pulse_cnt_r == LONG_LAST);
  wire       bidir_long = (state_r == ST_WAIT) && (irst_cnt_r == IRST_LAST) && pin_low
                          && may_drive;
  wire       irst_start = overflow || software_reset_instruction;
  wire       pin_done   = long_evt || short_evt;
  // Power-on flag lives in flags_r[4]
  wire       power_on_flag = flags_r[4];

  reg  [1:0]             state_nxt;
  reg  [`WDRS_CNT_W-1:0] pulse_cnt_nxt;
  reg  [`WDRS_CNT_W-1:0] irst_cnt_nxt;
  reg  [15:0]            rd_data_nxt;

  // Reset pin pulse classifier after the filter, and the internal reset timer
  always @* begin
    state_nxt     = state_r;
    pulse_cnt_nxt = pulse_cnt_r;
    irst_cnt_nxt  = irst_cnt_r;
    case (state_r)
      ST_IDLE: begin
        pulse_cnt_nxt = {`WDRS_CNT_W{1'b0}};
        if (pin_low && !reset_input_pin_oe_r) begin
          state_nxt = ST_PULSE;
        end
      end
      ST_PULSE: begin
        if (pulse_cnt_r != LONG_SAT) begin
          pulse_cnt_nxt = pulse_cnt_r + 1'b1;
        end
        if (!pin_low) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        irst_cnt_nxt = irst_cnt_r + 1'b1;
        if (irst_cnt_r == IRST_LAST) begin
          state_nxt = ST_IDLE;
        end
      end
    endcase
    // A new internal reset restarts the sequence from any state
    if (irst_start) begin
      state_nxt    = ST_WAIT;
      irst_cnt_nxt = {`WDRS_CNT_W{1'b0}};
    end
  end

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r     <= ST_IDLE;
      pulse_cnt_r <= {`WDRS_CNT_W{1'b0}};
      irst_cnt_r  <= {`WDRS_CNT_W{1'b0}};
    end else if (clk_en) begin
      state_r     <= state_nxt;
      pulse_cnt_r <= pulse_cnt_nxt;
      irst_cnt_r  <= irst_cnt_nxt;
    end
  end

  // Reset outputs; the reset pin is only ever pulled low, never driven high
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      internal_reset_r      <= 1'b0;
      reset_output_pin_b_r  <= 1'b0;
      reset_input_pin_out_r <= 1'b0;
      reset_input_pin_oe_r  <= 1'b0;
    end else if (clk_en) begin
      reset_input_pin_out_r <= 1'b0;
      if (state_r == ST_WAIT) begin
        if (irst_cnt_r == IRST_LAST) begin
          internal_reset_r     <= 1'b0;
          reset_output_pin_b_r <= 1'b1;
        end
        // Power-down going low mid-sequence lets go of the pin at once
        if (!may_drive || (irst_cnt_r == IRST_REL)) begin
          reset_input_pin_oe_r <= 1'b0;
        end
      end
      if (irst_start) begin
        internal_reset_r     <= 1'b1;
        reset_output_pin_b_r <= 1'b0;
        reset_input_pin_oe_r <= may_drive;
      end
      if (pin_done) begin
        internal_reset_r     <= 1'b0;
        reset_output_pin_b_r <= 1'b1;
      end
    end
  end

  // Watchdog counter
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_r   <= 7'h00;
      count_r <= 16'h0000;
    end else if (clk_en) begin
      // Divider runs free, so the first tick after a service may come early
      div_r <= wd_tick ? 7'h00 : div_r + 7'h01;
      if (irst_start || pin_done) begin
        count_r <= 16'h0000;
      end else if (service_instruction) begin
        count_r <= {reload_high_byte_r, 8'h00};
      end else if (wd_run && wd_tick) begin
        count_r <= count_r + 16'h0001;
      end
    end
  end

  // Software-visible settings
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      prescale_select_r  <= 1'b0;
      reload_high_byte_r <= 8'h00;
      bidir_r            <= 1'b0;
      irq_mask_r         <= {`WDRS_IRQ_W{1'b0}};
    end else if (clk_en) begin
      if (wr_ctrl) begin
        prescale_select_r  <= wr_data[`WDRS_BIT_PRESCALE];
        // Flag bits of the written word are dropped on purpose
        reload_high_byte_r <= wr_data[`WDRS_RELOAD_HI:`WDRS_RELOAD_LO];
      end
      if (wr_cfg) begin
        bidir_r <= wr_data[`WDRS_BIT_BIDIR];
      end
      if (wr_mask) begin
        irq_mask_r <= wr_data[`WDRS_IRQ_W-1:0];
      end
    end
  end

  // Startup window: disable is honoured only until end-of-init
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      init_done_r <= 1'b0;
      disable_r   <= 1'b0;
    end else if (clk_en) begin
      if (end_of_init_instruction) begin
        init_done_r <= 1'b1;
      end
      if (wr_cfg && !init_done_r) begin
        disable_r <= wr_data[`WDRS_BIT_DISABLE];
      end
      // Every reset sequence reopens the window with the watchdog running
      if (irst_start || pin_done) begin
        init_done_r <= 1'b0;
        disable_r   <= 1'b0;
      end
    end
  end

  // Flag slots: 0 watchdog, 1 software, 2 short, 3 long, 4 power-on; set wins over clear
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      flags_r <= 5'h10;
    end else if (clk_en) begin
      if (end_of_init_instruction) begin
        flags_r <= 5'h00;
      end
      if (service_instruction) begin
        flags_r[0] <= 1'b0;
      end
      if (overflow) begin
        flags_r[1:0] <= 2'b11;
      end
      if (software_reset_instruction) begin
        flags_r[1] <= 1'b1;
      end
      if (short_evt) begin
        flags_r[2:1] <= 2'b11;
      end
      if (long_evt || bidir_long || supply_fail_detect) begin
        flags_r[3:1] <= 3'b111;
      end
      if (power_on_detect) begin
        flags_r <= 5'h1e;
      end
    end
  end

  // Interrupt status: read clears, new event wins
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_stat_r <= {`WDRS_IRQ_W{1'b0}};
      irq_r      <= 1'b0;
    end else if (clk_en) begin
      irq_stat_r <= (rd_stat ? {`WDRS_IRQ_W{1'b0}} : irq_stat_r)
                    | {long_evt || bidir_long, short_evt, overflow};
      irq_r      <= |(irq_stat_r & irq_mask_r);
    end
  end

  // Read path; data stand for one cycle only and are zero otherwise
  always @* begin
    rd_data_nxt = 16'h0000;
    if (!rd_stb) begin
      rd_data_nxt = 16'h0000;
    end else if (ctrl_hit(addr) == 2'h1) begin
      rd_data_nxt = {reload_high_byte_r, 2'b00, power_on_flag, flags_r[3:0],
                     prescale_select_r};
    end else if (ctrl_hit(addr) == 2'h2) begin
      rd_data_nxt = {13'h0000, irq_stat_r};
    end else if (ctrl_hit(addr) == 2'h3) begin
      rd_data_nxt = {13'h0000, irq_mask_r};
    end else if (addr == `WDRS_ADDR_CFG) begin
      rd_data_nxt = {12'h000, init_done_r, 1'b0, bidir_r, disable_r};
    end
  end

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data_r <= 16'h0000;
    end else if (clk_en) begin
      rd_data_r <= rd_data_nxt;
    end
  end
endmodule // wdrs_watchdog

//--- tb/tb.sv
`timescale 1ns/100ps
`include "wdrs_regs.vh"
module tb;
  logic        core_clk, rst_b, wr_stb, rd_stb, rd_pend, ir_seen, pd;
  logic [15:0] addr, wr_data, rd_data_r;
  logic [4:0]  ev;
  logic [7:0]  rl;
  logic [31:0] n;
  logic [31:0] exp_q[$];
  wire         rin, oe, od, rout_b, ir, irq;
  int          fails, total_checks;
  int          pl[6] = '{0, 0, 0, 40, 600, 1};
  logic [4:0]  pv[6] = '{5'h10, 5'h08, 5'h04, 5'h00, 5'h00, 5'h00};
  logic [15:0] fx[6] = '{16'h003c, 16'h001c, 16'h0004, 16'h000c, 16'h001c, 16'h0000};
  wdrs_watchdog i_dut (
    .core_clk(core_clk), .rst_b(rst_b), .clk_en(1'b1), .addr(addr), .wr_data(wr_data),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data_r(rd_data_r),
    .end_of_init_instruction(ev[0]), .service_instruction(ev[1]),
    .software_reset_instruction(ev[2]), .supply_fail_detect(ev[3]),
    .power_on_detect(ev[4]), .reset_input_pin(rin), .power_down_pin(pd),
    .reset_output_pin_b_r(rout_b), .reset_input_pin_out_r(od),
    .reset_input_pin_oe_r(oe), .internal_reset_r(ir), .irq_r(irq));
  wdrs_rst_src i_src (.core_clk(core_clk), .dev_oe(oe), .dev_out(od), .pin(rin));
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  always @(negedge core_clk) if (ir === 1'b1) ir_seen = 1'b1;
  // Read data stand only in the cycle after the strobe
  always @(posedge core_clk) begin
    if (rd_pend === 1'b1) begin
      n = exp_q.pop_front();
      chk16(rd_data_r & n[31:16], n[15:0] & n[31:16]);
    end
    rd_pend <= rd_stb;
  end
  task automatic chk16(input logic [15:0] g, e);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task summarize;
    $display("checks=%0d mismatches=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task wr(input logic [15:0] a, d);
    @(posedge core_clk);
    {addr, wr_data, wr_stb} <= {a, d, 1'b1};
    @(posedge core_clk);
    wr_stb <= 1'b0;
  endtask
  task rd(input logic [15:0] a, e, m);
    exp_q.push_back({m, e});
    @(posedge core_clk);
    {addr, rd_stb} <= {a, 1'b1};
    @(posedge core_clk);
    rd_stb <= 1'b0;
  endtask
  task ins(input logic [4:0] v);
    @(posedge core_clk);
    ev <= v;
    @(posedge core_clk);
    ev <= 5'h00;
  endtask
  task rst_dut;
    rst_b <= 1'b0;
    repeat (5) @(posedge core_clk);
    rst_b <= 1'b1;
  endtask
  // Divider phase is free running, so the divide-by-128 window is wider
  task wd_run(input logic [7:0] r, input logic p, f);
    wr(`WDRS_ADDR_CTRL, {r, 7'h00, p});
    ins(5'h02);
    ir_seen = 1'b0;
    repeat ((256 - r) * (p ? 32768 : 512) - (p ? 160 : 20)) @(posedge core_clk);
    chk16({15'h0, ir_seen}, 16'h0000);
    repeat (p ? 200 : 60) @(posedge core_clk);
    chk16({15'h0, ir_seen}, {15'h0, f});
  endtask
  initial begin
    {rst_b, wr_stb, rd_stb, ev, addr, wr_data} = '0;
    pd = 1'b1;
    void'($urandom(32'hd09e896d));
    rst_dut;
    rd(`WDRS_ADDR_CTRL, 16'h0020, 16'hffff);
    wr(`WDRS_ADDR_CTRL, 16'hffff);
    rd(`WDRS_ADDR_CTRL, 16'hff21, 16'hffff);
    rd(16'hffa0, 16'h0000, 16'hffff);
    for (int k = 0; k < 2; k++) begin
      wr(`WDRS_ADDR_IRQ_MASK, k ? 16'hffff : 16'h0000);
      i_src.pulse(40);
      repeat (40) @(posedge core_clk);
      chk16({15'h0, irq}, {15'h0, 1'(k)});
      rd(`WDRS_ADDR_IRQ_STAT, 16'h0002, 16'h0002);
      repeat (3) @(posedge core_clk);
      chk16({15'h0, irq}, 16'h0000);
    end
    ins(5'h01);
    for (int i = 0; i < 6; i++) begin
      pd <= (i > 2);
      repeat (8) @(posedge core_clk);
      if (pl[i] > 0) i_src.pulse(pl[i]);
      else ins(pv[i]);
      repeat (40) @(posedge core_clk);
      rd(`WDRS_ADDR_CTRL, fx[i], 16'h003e);
      ins(5'h01);
      rd(`WDRS_ADDR_CTRL, 16'h0000, 16'h003e);
    end
    pd <= 1'b0;
    wr(`WDRS_ADDR_CFG, 16'h0002);
    repeat (8) @(posedge core_clk);
    ins(5'h04);
    pd <= 1'b1;
    repeat (40) @(posedge core_clk);
    wr(`WDRS_ADDR_CFG, 16'h0002);
    repeat (8) @(posedge core_clk);
    fork
      ins(5'h04);
      i_src.pulse(60);
    join
    repeat (40) @(posedge core_clk);
    rd(`WDRS_ADDR_CTRL, 16'h001c, 16'h003e);
    // Let the pending read data be compared before reset clears them
    @(posedge core_clk);
    rst_dut;
    wr(`WDRS_ADDR_CFG, 16'h0001);
    wd_run(8'hff, 1'b0, 1'b0);
    rst_dut;
    ins(5'h01);
    wr(`WDRS_ADDR_CFG, 16'h0001);
    wd_run(8'hff, 1'b0, 1'b1);
    rd(`WDRS_ADDR_CTRL, 16'h0006, 16'h003e);
    ins(5'h02);
    rd(`WDRS_ADDR_CTRL, 16'h0004, 16'h0006);
    rl = 8'hf8 | 8'($urandom % 8);
    wd_run(rl, 1'b0, 1'b1);
    wd_run(8'hff, 1'b1, 1'b1);
    summarize;
  end
  initial begin
    #2000000;
    fails++;
    summarize;
  end
endmodule // tb

//--- tb/wdrs_rst_src.sv
`timescale 1ns/100ps
// Board reset source; the line has a pull-up, both parties only pull low
module wdrs_rst_src (
  input  wire core_clk,
  input  wire dev_oe,
  input  wire dev_out,
  output wire pin
);
  logic src_low_r = 1'b0;
  assign pin = (src_low_r || (dev_oe && !dev_out)) ? 1'b0 : 1'b1;
  // Holds the line low for n whole cycles
  task automatic pulse(input int n);
    @(posedge core_clk);
    src_low_r <= 1'b1;
    repeat (n) @(posedge core_clk);
    src_low_r <= 1'b0;
  endtask
endmodule // wdrs_rst_src

//--- tb/wdrs_watchdog_asserts.sv
`timescale 1ns/100ps
module wdrs_watchdog_asserts (
  input wire        core_clk,
  input wire        rst_b,
  input wire        rd_stb,
  input wire [15:0] rd_data_r,
  input wire        software_reset_instruction,
  input wire        reset_input_pin,
  input wire        power_down_pin,
  input wire        reset_output_pin_b_r,
  input wire        reset_input_pin_out_r,
  input wire        reset_input_pin_oe_r,
  input wire        internal_reset_r
);
  // Length of the running internal reset, zero while idle
  reg [4:0] ir_cnt_r;
  always @(posedge core_clk or negedge rst_b)
    if (!rst_b)
      ir_cnt_r <= 5'h00;
    else
      ir_cnt_r <= internal_reset_r ? ir_cnt_r + 5'h01 : 5'h00;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  chk_rd_idle_zero: assert property (!$past(rd_stb) |-> rd_data_r == 16'h0000)
    else $error("read data not idle");
  chk_pin_od: assert property (reset_input_pin_oe_r |-> !reset_input_pin_out_r)
    else $error("reset pin driven high");
  chk_pd_blocks: assert property (!power_down_pin [*6] |-> !reset_input_pin_oe_r)
    else $error("reset pin pulled with power-down low");
  chk_ir_out_low: assert property (internal_reset_r |-> !reset_output_pin_b_r)
    else $error("reset output high in internal reset");
  chk_ir_length: assert property ($fell(internal_reset_r) |-> ir_cnt_r == 5'd16)
    else $error("internal reset length wrong");
  chk_ir_bound: assert property (ir_cnt_r <= 5'd16)
    else $error("internal reset too long");
  chk_swr_resets: assert property ($rose(software_reset_instruction)
    |-> ##[1:8] internal_reset_r) else $error("no internal reset");
  chk_spike_drop: assert property ($rose(reset_input_pin) && $past(reset_input_pin, 2)
    |=> $stable(reset_output_pin_b_r) [*4]) else $error("spike reached reset output");
endmodule // wdrs_watchdog_asserts
bind wdrs_watchdog wdrs_watchdog_asserts i_chk (
  .core_clk(core_clk), .rst_b(rst_b), .rd_stb(rd_stb), .rd_data_r(rd_data_r),
  .software_reset_instruction(software_reset_instruction),
  .reset_input_pin(reset_input_pin), .power_down_pin(power_down_pin),
  .reset_output_pin_b_r(reset_output_pin_b_r),
  .reset_input_pin_out_r(reset_input_pin_out_r),
  .reset_input_pin_oe_r(reset_input_pin_oe_r), .internal_reset_r(internal_reset_r));
